// ---- hdl/rxcr_xcvr_rx.sv ----
// transceiver end: clock recovery, deserializer and read-side FIFO
`timescale 1ns/1ns
`include "rxcr_consts.svh"
module rxcr_xcvr_rx #(
   parameter int NCH   = `RXCR_NCH,
   parameter int W     = `RXCR_WORD_BITS,
   parameter int DEPTH = `RXCR_FIFO_DEPTH
) (
   input  wire logic                clk_sys,
   input  wire logic                reset,
   rxcr_link_if.dev                 lnk,
   input  wire logic [NCH-1:0]      ser_bit,
   input  wire logic [NCH-1:0]      ser_vld,
   output logic [NCH-1:0][W-1:0]    rx_word,
   output logic [NCH-1:0]           rx_vld,
   output logic [NCH-1:0]           rx_ovf,
   output logic [NCH-1:0]           rx_locked
);
   localparam int AW   = $clog2(DEPTH);
   localparam int HALF = W / 2;
   localparam logic [AW:0] FULL  = (AW+1)'(DEPTH);
   localparam logic [3:0]  EDGES = 4'(`RXCR_LOCK_EDGES - 1);
   localparam logic [3:0]  HLAST = 4'(HALF - 1);

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      // reset inputs are taken level by level, each one alone
      logic ana;
      logic dig;
      assign ana = reset | lnk.ana_rst[i];
      assign dig = reset | lnk.dig_rst[i];

      // clock recovery state
      rxcr_pkg::rxcr_cdr_t cdr_q, cdr_d;
      logic [3:0] edg_q, edg_d;
      logic [3:0] bc_q, bc_d;
      logic       last_q, last_d;
      logic       pclk_q, pclk_d;
      logic       pma_q, pma_d;
      logic       lck_q, lck_d;
      logic       trans;

      assign trans = ser_vld[i] & (ser_bit[i] != last_q);

      always_comb begin
         cdr_d  = cdr_q;
         edg_d  = edg_q;
         bc_d   = bc_q;
         last_d = last_q;
         pclk_d = pclk_q;
         pma_d  = pma_q;
         lck_d  = 1'b0;
         if (ana) begin
            cdr_d  = rxcr_pkg::RXCR_CDR_RST;
            edg_d  = '0;
            // idle line level, so the first bit after reset can count
            last_d = 1'b0;
            bc_d   = '0;
            pclk_d = 1'b0;
            pma_d  = 1'b0;
         end else begin
            if (ser_vld[i]) begin
               last_d = ser_bit[i];
               pma_d  = ~pma_q;
            end
            case (cdr_q)
               rxcr_pkg::RXCR_CDR_RST: begin
                  if (lnk.lock_to_ref[i]) begin
                     cdr_d = rxcr_pkg::RXCR_CDR_REF;
                  end else begin
                     cdr_d = rxcr_pkg::RXCR_CDR_ACQ;
                  end
               end
               rxcr_pkg::RXCR_CDR_ACQ: begin
                  if (lnk.lock_to_ref[i]) begin
                     cdr_d = rxcr_pkg::RXCR_CDR_REF;
                  end else if (trans) begin
                     edg_d = edg_q + 1'b1;
                     if (edg_q == EDGES) begin
                        cdr_d = rxcr_pkg::RXCR_CDR_DATA;
                        bc_d  = '0;
                     end
                  end
               end
               rxcr_pkg::RXCR_CDR_DATA: begin
                  lck_d = 1'b1;
                  if (lnk.lock_to_ref[i]) begin
                     cdr_d = rxcr_pkg::RXCR_CDR_REF;
                  end else if (ser_vld[i]) begin
                     // half a word of bits per clock phase
                     if (bc_q == HLAST) begin
                        bc_d   = '0;
                        pclk_d = ~pclk_q;
                     end else begin
                        bc_d = bc_q + 1'b1;
                     end
                  end
               end
               rxcr_pkg::RXCR_CDR_REF: begin
                  lck_d = 1'b1;
                  if (!lnk.lock_to_ref[i]) begin
                     cdr_d = rxcr_pkg::RXCR_CDR_ACQ;
                     edg_d = '0;
                     lck_d = 1'b0;
                  end else begin
                     pclk_d = lnk.refclk[`RXCR_REF_SEL];
                  end
               end
               default: begin
                  cdr_d = rxcr_pkg::RXCR_CDR_RST;
               end
            endcase
         end
      end

      always_ff @(posedge clk_sys) begin
         cdr_q  <= cdr_d;
         edg_q  <= edg_d;
         bc_q   <= bc_d;
         last_q <= last_d;
         pclk_q <= pclk_d;
         pma_q  <= pma_d;
         lck_q  <= lck_d;
      end

      assign lnk.par_clk[i] = pclk_q;
      assign lnk.pma_clk[i] = pma_q;
      assign rx_locked[i]   = lck_q;

      // deserializer runs only once the channel is locked
      logic [W-1:0] dword;
      logic         dstb;
      logic         shen;

      assign shen = ser_vld[i] & ~ana &
                    ((cdr_q == rxcr_pkg::RXCR_CDR_DATA) |
                     (cdr_q == rxcr_pkg::RXCR_CDR_REF));

      rxcr_deser #(
         .W        (W)
      ) u_deser (
         .clk_sys  (clk_sys),
         .clr      (ana),
         .shift_en (shen),
         .bit_in   (ser_bit[i]),
         .word     (dword),
         .word_stb (dstb)
      );

      // phase compensation FIFO, read side paced by the core clock
      logic [W-1:0]  mem_q [DEPTH];
      logic [AW-1:0] wp_q, wp_d;
      logic [AW-1:0] rp_q, rp_d;
      logic [AW:0]   fill_q, fill_d;
      logic          cc_q, cc_d;
      logic [W-1:0]  word_q, word_d;
      logic          vld_q, vld_d;
      logic          ovf_q, ovf_d;
      logic          push;
      logic          pop;
      logic          rd_edge;

      assign rd_edge = lnk.core_clk[i] & ~cc_q;
      assign push    = dstb & (fill_q != FULL) & ~dig;
      assign pop     = rd_edge & (fill_q != '0) & ~dig;

      always_comb begin
         wp_d   = wp_q;
         rp_d   = rp_q;
         fill_d = fill_q;
         cc_d   = lnk.core_clk[i];
         word_d = word_q;
         vld_d  = 1'b0;
         ovf_d  = ovf_q;
         if (dig) begin
            wp_d   = '0;
            rp_d   = '0;
            fill_d = '0;
            word_d = '0;
            ovf_d  = 1'b0;
         end else begin
            if (push) begin
               wp_d = wp_q + 1'b1;
            end
            if (pop) begin
               rp_d   = rp_q + 1'b1;
               word_d = mem_q[rp_q];
               vld_d  = 1'b1;
            end
            case ({push, pop})
               2'b10:   fill_d = fill_q + 1'b1;
               2'b01:   fill_d = fill_q - 1'b1;
               default: fill_d = fill_q;
            endcase
            // a word that finds the FIFO full is dropped and noted
            if (dstb && fill_q == FULL) begin
               ovf_d = 1'b1;
            end
         end
      end

      always_ff @(posedge clk_sys) begin
         wp_q   <= wp_d;
         rp_q   <= rp_d;
         fill_q <= fill_d;
         cc_q   <= cc_d;
         word_q <= word_d;
         vld_q  <= vld_d;
         ovf_q  <= ovf_d;
      end

      always_ff @(posedge clk_sys) begin
         if (push) begin
            mem_q[wp_q] <= dword;
         end
      end

      assign rx_word[i] = word_q;
      assign rx_vld[i]  = vld_q;
      assign rx_ovf[i]  = ovf_q;
   end
endmodule // rxcr_xcvr_rx

// ---- hdl/rxcr_consts.svh ----
// constants of the receive transceiver clock and reset pair
// Behaviour
// - analog reset clears recovery circuit and deserializer
// - digital reset clears receive digital data path
// - only the reset controller drives both resets; the transceiver also ORs its own reset input into each
// - lock-to-data: parallel clock recovered from data
// - lock-to-reference: parallel clock mirrors selected reference
// - core clock reads FIFO, fed from parallel clock
// - reference bit0 core PLL, bit1 TMDS; select 0
// - recovered PMA clock stays unconnected and unused
// - below minimum rate: faster reference, oversampled stream
// - cover 250 to 6000 Mbps, below 611 via PLL reference
// - lock-to-reference control high selects reference mode
`ifndef RXCR_CONSTS_SVH
`define RXCR_CONSTS_SVH

`define RXCR_NCH        3
`define RXCR_WORD_BITS  10
`define RXCR_REF_SEL    0
`define RXCR_REF_PLL    0
`define RXCR_REF_TMDS   1
`define RXCR_FIFO_DEPTH 4
`define RXCR_LOCK_EDGES 8
`define RXCR_OS_FACTOR  5
`define RXCR_RATE_MIN   250
`define RXCR_RATE_MAX   6000
`define RXCR_LINK_MIN   611
`define RXCR_CLK_MHZ    100
`define RXCR_T_ANA_NS   1000
`define RXCR_T_LOCK_NS  4000
`define RXCR_ANA_CYC  ((`RXCR_T_ANA_NS * `RXCR_CLK_MHZ + 999) / 1000)
`define RXCR_LOCK_CYC ((`RXCR_T_LOCK_NS * `RXCR_CLK_MHZ + 999) / 1000)

`endif

// ---- hdl/rxcr_pkg.sv ----
// types shared by both ends of the receive clock and reset pair
package rxcr_pkg;
   typedef enum logic [1:0] {
      RXCR_CDR_RST  = 2'b00,
      RXCR_CDR_ACQ  = 2'b01,
      RXCR_CDR_DATA = 2'b10,
      RXCR_CDR_REF  = 2'b11
   } rxcr_cdr_t;

   typedef enum logic [2:0] {
      RXCR_RC_IDLE = 3'b000,
      RXCR_RC_ANA  = 3'b001,
      RXCR_RC_LOCK = 3'b010,
      RXCR_RC_RUN  = 3'b011,
      RXCR_RC_ERR  = 3'b100
   } rxcr_rc_t;
endpackage

// ---- hdl/rxcr_link_if.sv ----
// interface between the transceiver end and the reset controller end
`timescale 1ns/1ns
`include "rxcr_consts.svh"
interface rxcr_link_if #(
   parameter int NCH = `RXCR_NCH
);
   logic [1:0]     refclk;
   logic [NCH-1:0] ana_rst;
   logic [NCH-1:0] dig_rst;
   logic [NCH-1:0] lock_to_ref;
   logic [NCH-1:0] par_clk;
   logic [NCH-1:0] core_clk;
   logic [NCH-1:0] pma_clk;

   modport dev (
      input  refclk,
      input  ana_rst,
      input  dig_rst,
      input  lock_to_ref,
      input  core_clk,
      output par_clk,
      output pma_clk
   );

   modport ctl (
      output refclk,
      output ana_rst,
      output dig_rst,
      output lock_to_ref,
      output core_clk,
      input  par_clk,
      input  pma_clk
   );
endinterface

// ---- hdl/rxcr_deser.sv ----
// serial to parallel converter of one receive channel
`timescale 1ns/1ns
`include "rxcr_consts.svh"
module rxcr_deser #(
   parameter int W = `RXCR_WORD_BITS
) (
   input  wire logic         clk_sys,
   input  wire logic         clr,
   input  wire logic         shift_en,
   input  wire logic         bit_in,
   output logic [W-1:0]      word,
   output logic              word_stb
);
   localparam int CW = $clog2(W);

   logic [W-1:0]  sh_q, sh_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic [W-1:0]  word_q, word_d;
   logic          stb_q, stb_d;

   // bits arrive first bit first, so they enter at the top
   always_comb begin
      sh_d   = sh_q;
      cnt_d  = cnt_q;
      word_d = word_q;
      stb_d  = 1'b0;
      if (clr) begin
         sh_d   = '0;
         cnt_d  = '0;
         word_d = '0;
      end else if (shift_en) begin
         sh_d = {bit_in, sh_q[W-1:1]};
         if (cnt_q == CW'(W - 1)) begin
            cnt_d  = '0;
            word_d = {bit_in, sh_q[W-1:1]};
            stb_d  = 1'b1;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      sh_q   <= sh_d;
      cnt_q  <= cnt_d;
      word_q <= word_d;
      stb_q  <= stb_d;
   end

   assign word     = word_q;
   assign word_stb = stb_q;
endmodule // rxcr_deser

// ---- hdl/rxcr_rst_ctl.sv ----
// reset controller end: resets, reference clocks and core clocks
`timescale 1ns/1ns
`include "rxcr_consts.svh"
module rxcr_rst_ctl #(
   parameter int NCH  = `RXCR_NCH,
   parameter int HP_W = 8
) (
   input  wire logic            clk_sys,
   input  wire logic            reset,
   rxcr_link_if.ctl             lnk,
   input  wire logic            tmds_clk,
   input  wire logic [12:0]     rate_mbps,
   input  wire logic            restart,
   output logic [NCH-1:0]       user_rst,
   output logic                 ready,
   output logic                 rate_err,
   output logic                 oversample
);
   localparam logic [9:0] ANA_LAST  = 10'(`RXCR_ANA_CYC - 1);
   localparam logic [9:0] LOCK_LAST = 10'(`RXCR_LOCK_CYC - 1);

   rxcr_pkg::rxcr_rc_t st_q, st_d;
   logic [9:0]      cnt_q, cnt_d;
   logic            os_q, os_d;
   logic            bad;
   logic            ana_q, ana_d;
   logic            dig_q, dig_d;
   logic            tq_q, tq_d;
   logic [HP_W-1:0] hpc_q, hpc_d;
   logic [HP_W-1:0] hp_q, hp_d;
   logic [HP_W-1:0] div_q, div_d;
   logic [HP_W-1:0] tgt;
   logic            r0_q, r0_d;
   logic [NCH-1:0]  cc_q;
   logic            rdy_q, rdy_d;
   logic            err_q, err_d;

   assign bad  = (rate_mbps < 13'(`RXCR_RATE_MIN)) |
                 (rate_mbps > 13'(`RXCR_RATE_MAX));
   assign os_d = rate_mbps < 13'(`RXCR_LINK_MIN);

   // core PLL: follow the TMDS half period, five times faster when
   // the stream must be oversampled
   always_comb begin
      tq_d  = tmds_clk;
      hpc_d = hpc_q;
      hp_d  = hp_q;
      if (tmds_clk != tq_q) begin
         hp_d  = hpc_q;
         hpc_d = HP_W'(1);
      end else if (hpc_q != '1) begin
         hpc_d = hpc_q + 1'b1;
      end
      tgt = os_q ? HP_W'(hp_q / `RXCR_OS_FACTOR) : hp_q;
      if (tgt == '0) begin
         tgt = HP_W'(1);
      end
      div_d = div_q + 1'b1;
      r0_d  = r0_q;
      if (div_d >= tgt) begin
         div_d = '0;
         r0_d  = ~r0_q;
      end
   end

   // sequence: both resets, then analog released, then digital
   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q + 1'b1;
      ana_d = 1'b1;
      dig_d = 1'b1;
      case (st_q)
         rxcr_pkg::RXCR_RC_IDLE: begin
            st_d  = rxcr_pkg::RXCR_RC_ANA;
            cnt_d = '0;
         end
         rxcr_pkg::RXCR_RC_ANA: begin
            if (cnt_q == ANA_LAST) begin
               st_d  = rxcr_pkg::RXCR_RC_LOCK;
               cnt_d = '0;
               ana_d = 1'b0;
            end
         end
         rxcr_pkg::RXCR_RC_LOCK: begin
            ana_d = 1'b0;
            if (cnt_q == LOCK_LAST) begin
               st_d  = rxcr_pkg::RXCR_RC_RUN;
               dig_d = 1'b0;
            end
         end
         rxcr_pkg::RXCR_RC_RUN: begin
            ana_d = 1'b0;
            dig_d = 1'b0;
            cnt_d = '0;
            if (restart || os_d != os_q) begin
               st_d  = rxcr_pkg::RXCR_RC_ANA;
               ana_d = 1'b1;
               dig_d = 1'b1;
            end
         end
         rxcr_pkg::RXCR_RC_ERR: begin
            cnt_d = '0;
            if (!bad) begin
               st_d = rxcr_pkg::RXCR_RC_ANA;
            end
         end
         default: begin
            st_d = rxcr_pkg::RXCR_RC_IDLE;
         end
      endcase
      if (bad) begin
         st_d  = rxcr_pkg::RXCR_RC_ERR;
         cnt_d = '0;
         ana_d = 1'b1;
         dig_d = 1'b1;
      end
      rdy_d = ~dig_d;
      err_d = (st_d == rxcr_pkg::RXCR_RC_ERR);
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_q  <= rxcr_pkg::RXCR_RC_IDLE;
         cnt_q <= '0;
         os_q  <= 1'b0;
         ana_q <= 1'b1;
         dig_q <= 1'b1;
         tq_q  <= 1'b0;
         hpc_q <= '0;
         hp_q  <= '0;
         div_q <= '0;
         r0_q  <= 1'b0;
         cc_q  <= '0;
         rdy_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         os_q  <= os_d;
         ana_q <= ana_d;
         dig_q <= dig_d;
         tq_q  <= tq_d;
         hpc_q <= hpc_d;
         hp_q  <= hp_d;
         div_q <= div_d;
         r0_q  <= r0_d;
         cc_q  <= lnk.par_clk;
         rdy_q <= rdy_d;
         err_q <= err_d;
      end
   end

   assign lnk.ana_rst     = {NCH{ana_q}};
   assign lnk.dig_rst     = {NCH{dig_q}};
   assign lnk.lock_to_ref = {NCH{os_q}};
   assign lnk.refclk      = {tq_q, r0_q};
   assign lnk.core_clk    = cc_q;
   // the recovered PMA clock is left unread
   assign user_rst   = {NCH{dig_q}};
   assign ready      = rdy_q;
   assign rate_err   = err_q;
   assign oversample = os_q;
endmodule // rxcr_rst_ctl

// ---- verif/rxcr_link_props.sv ----
// assertions on the link between the two receive ends
`timescale 1ns/1ns
module rxcr_link_props #(
   parameter int NCH = 3
) (
   input wire logic           clk_sys,
   input wire logic           reset,
   input wire logic [1:0]     refclk,
   input wire logic [NCH-1:0] ana_rst,
   input wire logic [NCH-1:0] dig_rst,
   input wire logic [NCH-1:0] lock_to_ref,
   input wire logic [NCH-1:0] par_clk,
   input wire logic [NCH-1:0] core_clk
);
   logic [9:0] ana_n_q;
   logic [9:0] lock_n_q;

   // length of the analog pulse and of the lock wait that follows it
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ana_n_q  <= 10'h0;
         lock_n_q <= 10'h0;
      end else begin
         ana_n_q  <= ana_rst[0] ? ana_n_q + {9'h0, ~&ana_n_q} : 10'h0;
         lock_n_q <= (dig_rst[0] && !ana_rst[0]) ? lock_n_q + 10'h1 : 10'h0;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   resets_equal_a: assert property (
      (&ana_rst || !(|ana_rst)) && (&dig_rst || !(|dig_rst)))
      else $error("channel resets differ");
   ana_first_a: assert property ($fell(ana_rst[0]) |-> dig_rst[0])
      else $error("digital reset released before analog");
   // a rate fault stretches the pulse, so only its floor is fixed
   ana_len_a: assert property (
      $fell(ana_rst[0]) |-> ana_n_q >= 10'h064)
      else $error("analog reset pulse too short");
   lock_len_a: assert property (
      $fell(dig_rst[0]) |-> lock_n_q == 10'h190)
      else $error("lock wait length wrong");
   ana_quiet_a: assert property ((&ana_rst)[*3] |-> par_clk == '0)
      else $error("parallel clock runs in analog reset");
   ref_mirror_a: assert property (
      (lock_to_ref[0] && !ana_rst[0])[*4] |-> par_clk[0] == $past(refclk[0]))
      else $error("parallel clock does not follow reference");
   core_follow_a: assert property (
      !$past(reset) |-> core_clk == $past(par_clk))
      else $error("core clock not fed from parallel clock");
   lock_uniform_a: assert property (lock_to_ref == '0 || &lock_to_ref)
      else $error("lock mode differs between channels");
endmodule // rxcr_link_props

// ---- verif/tb.sv ----
// self-checking bench for the receive clock and reset pair
`timescale 1ns/1ns
`include "rxcr_consts.svh"
module tb;
   logic            clk_sys    = 1'b0;
   logic            reset      = 1'b1;
   logic            tmds_clk   = 1'b0;
   logic [12:0]     rate_mbps  = 13'h5cd;
   logic            restart    = 1'b0;
   logic [2:0]      ser_bit    = 3'h0;
   logic [2:0]      ser_vld    = 3'h0;
   logic [2:0][9:0] rx_word;
   logic [2:0]      rx_vld;
   logic [2:0]      rx_ovf;
   logic [2:0]      rx_locked;
   logic [2:0]      user_rst;
   logic            ready;
   logic            rate_err;
   logic            oversample;
   logic [9:0]      got[$];
   int              errors     = 0;
   int              n_compared = 0;

   rxcr_link_if #(.NCH(3)) lnk ();
   rxcr_xcvr_rx rxcr_xcvr_rx_i (.clk_sys(clk_sys), .reset(reset),
      .lnk(lnk), .ser_bit(ser_bit), .ser_vld(ser_vld), .rx_word(rx_word),
      .rx_vld(rx_vld), .rx_ovf(rx_ovf), .rx_locked(rx_locked));
   rxcr_rst_ctl rxcr_rst_ctl_i (.clk_sys(clk_sys), .reset(reset),
      .lnk(lnk), .tmds_clk(tmds_clk), .rate_mbps(rate_mbps),
      .restart(restart), .user_rst(user_rst), .ready(ready),
      .rate_err(rate_err), .oversample(oversample));
   rxcr_link_props #(.NCH(3)) rxcr_link_props_i (.clk_sys(clk_sys),
      .reset(reset), .refclk(lnk.refclk), .ana_rst(lnk.ana_rst),
      .dig_rst(lnk.dig_rst), .lock_to_ref(lnk.lock_to_ref),
      .par_clk(lnk.par_clk), .core_clk(lnk.core_clk));

   always #5 clk_sys = ~clk_sys;
   always #30 tmds_clk = ~tmds_clk;
   always @(posedge clk_sys) if (rx_vld[0] === 1'b1) got.push_back(rx_word[0]);

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up();
      if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic wait_rdy();
      int n;
      n = 0;
      repeat (4) @(negedge clk_sys);
      while (ready !== 1'b1 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      chk("ready", ready, 1'b1);
   endtask

   task automatic send_bit(input logic b);
      ser_bit = {3{b}};
      ser_vld = 3'h7;
      @(negedge clk_sys);
      ser_vld = 3'h0;
      repeat (3) @(negedge clk_sys);
   endtask

   task automatic t_rate();
      rate_mbps = 13'h0f9;
      repeat (4) @(negedge clk_sys);
      chk("rate_err", rate_err, 1'b1);
      chk("ana_rst", lnk.ana_rst, 3'h7);
      chk("dig_rst", lnk.dig_rst, 3'h7);
      chk("ready", ready, 1'b0);
      rate_mbps = 13'h1771;
      repeat (4) @(negedge clk_sys);
      chk("rate_err", rate_err, 1'b1);
      rate_mbps = 13'h1770;
      wait_rdy();
      chk("rate_err", rate_err, 1'b0);
      chk("oversample", oversample, 1'b0);
      rate_mbps = 13'h0fa;
      wait_rdy();
      chk("oversample", oversample, 1'b1);
      chk("lock_to_ref", lnk.lock_to_ref, 3'h7);
      rate_mbps = 13'h262;
      repeat (4) @(negedge clk_sys);
      chk("ready", ready, 1'b1);
      rate_mbps = 13'h263;
      wait_rdy();
      chk("oversample", oversample, 1'b0);
      chk("lock_to_ref", lnk.lock_to_ref, 3'h0);
   endtask

   task automatic t_lock();
      int         n;
      logic       b;
      logic [9:0] w[3] = '{10'h2b5, 10'h0f3, 10'h1c8};
      n = 0;
      b = 1'b0;
      got.delete();
      chk("rx_locked", rx_locked, 3'h0);
      while (rx_locked !== 3'h7 && n < 40) begin
         b = ~b;
         send_bit(b);
         n++;
      end
      chk("rx_locked", rx_locked, 3'h7);
      chk("lock bits", n == 8, 1'b1);
      for (int k = 0; k < 4; k++)
         for (int i = 0; i < 10; i++) send_bit(w[k % 3][i]);
      repeat (4) @(negedge clk_sys);
      chk("words", got.size() >= 2, 1'b1);
      if (got.size() >= 2) begin
         chk("word0", got[0], w[0]);
         chk("word1", got[1], w[1]);
      end
      chk("rx_ovf", rx_ovf, 3'h0);
   endtask

   task automatic t_restart();
      restart = 1'b1;
      @(negedge clk_sys);
      restart = 1'b0;
      repeat (6) @(negedge clk_sys);
      chk("ana_rst", lnk.ana_rst, 3'h7);
      chk("user_rst", user_rst, 3'h7);
      chk("rx_locked", rx_locked, 3'h0);
      wait_rdy();
      chk("user_rst", user_rst, 3'h0);
   endtask

   task automatic t_ref();
      int   np;
      int   nt;
      logic pp;
      logic pt;
      logic pr;
      np = 0;
      nt = 0;
      rate_mbps = 13'h12c;
      wait_rdy();
      pp = lnk.par_clk[0];
      pt = lnk.refclk[1];
      pr = lnk.refclk[0];
      repeat (40) begin
         @(negedge clk_sys);
         chk("par_clk", lnk.par_clk[0], pr);
         pr = lnk.refclk[0];
         if (lnk.par_clk[0] === 1'b1 && pp === 1'b0) np++;
         if (lnk.refclk[1] === 1'b1 && pt === 1'b0) nt++;
         pp = lnk.par_clk[0];
         pt = lnk.refclk[1];
      end
      chk("rx_locked", rx_locked, 3'h7);
      chk("par_clk rises", np > 0, 1'b1);
      chk("refclk1 rises", nt > 0, 1'b1);
   endtask

   initial begin
      repeat (4) @(negedge clk_sys);
      reset = 1'b0;
      wait_rdy();
      chk("user_rst", user_rst, 3'h0);
      t_rate();
      t_lock();
      t_restart();
      t_ref();
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      wrap_up();
   end
endmodule // tb
